// ---- two_wire_bus_control.sv ----
`timescale 1ns/1ps
// Summary of operation
// - disabled: lines released, inputs ignored, stop cleared
// - start bit low: no start generated
// - start bit: start when free, else after stop
// - start bit as active master, after a byte: repeated start
// - start bit writable any time, even as slave
// - master stop driven, bit cleared on detection
// - slave stop: internal only, unaddressed, cleared
// - start and stop: stop first, then start
// - new state code sets event flag, except F8
// - event flag plus both enables requests interrupt
// - event flag stretches clock low, never pulls high
// - only software clears event flag
// - ack bit low: not acknowledge received data
// - ack bit high: acknowledge address and data
// - general call enable gates general call match
// - slave compares upper seven own address bits
module two_wire_bus_control
	import two_wire_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire line_pair_t line_in,
	output line_pair_t line_out,
	output line_pair_t line_oe,
	output logic serial_irq,
	output logic irq
);

	typedef struct packed {
		ctl_state_t st;
		logic [1:0] phase;
		logic [TIMER_W-1:0] timer;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic ens;
		logic start_request_bit;
		logic stop_request_bit;
		logic si;
		logic aa;
		logic [7:0] code;
		logic [7:0] data;
		logic [7:0] own;
		logic glob_en;
		logic ser_en;
		logic [EV_W-1:0] ev;
		logic [EV_W-1:0] ev_mask;
		logic master;
		logic tx;
		logic addr_byte;
		logic byte_done;
		logic rep;
		logic acked;
		logic gcall;
		logic addressed;
		logic load_pend;
		logic busy;
		logic drv_scl;
		logic drv_sda;
		logic hold_scl;
		logic ap_valid;
		logic ap_write;
		logic [7:0] ap_addr;
	} ctl_regs_t;

	ctl_regs_t r;
	ctl_regs_t next_r;
	bus_sense_t s;
	logic load;
	logic [7:0] load_val;
	logic [EV_W-1:0] ev_set;
	logic match_own;
	logic match_gc;
	logic [31:0] rd;

	bus_sense sense_inst (
		.clock(clock),
		.rst(rst),
		.line_in(line_in),
		.sense(s)
	);

	always_comb begin
		next_r = r;
		load = 1'b0;
		load_val = C_IDLE;
		ev_set = '0;
		match_own = 1'b0;
		match_gc = 1'b0;

		// ************************************************************
		// register writes (data phase)
		// ************************************************************
		if (r.ap_valid && r.ap_write) begin
			unique case (r.ap_addr)
				OFF_CTRL: begin
					next_r.ens = hwdata[CTL_ENS];
					next_r.start_request_bit = hwdata[CTL_STA];
					next_r.stop_request_bit = hwdata[CTL_STO];
					if (!hwdata[CTL_SI]) begin
						next_r.si = 1'b0;
					end
					next_r.aa = hwdata[CTL_AA];
				end
				OFF_DATA: next_r.data = hwdata[7:0];
				OFF_OWN: next_r.own = hwdata[7:0];
				OFF_IEN: begin
					next_r.glob_en = hwdata[IEN_GLOBAL];
					next_r.ser_en = hwdata[IEN_SERIAL];
				end
				OFF_EV: next_r.ev = r.ev & ~hwdata[EV_W-1:0];
				OFF_MASK: next_r.ev_mask = hwdata[EV_W-1:0];
				default: ;
			endcase
		end
		next_r.ap_valid = hsel & hready & htrans[1];
		next_r.ap_write = hwrite;
		next_r.ap_addr = haddr[7:0];

		// ************************************************************
		// bus engine
		// ************************************************************
		if (!r.ens) begin
			next_r.st = S_IDLE;
			next_r.stop_request_bit = 1'b0;
			next_r.master = 1'b0;
			next_r.addressed = 1'b0;
			next_r.load_pend = 1'b0;
			next_r.busy = 1'b0;
			next_r.drv_scl = 1'b0;
			next_r.drv_sda = 1'b0;
			next_r.hold_scl = 1'b0;
		end else begin
			if (s.start_det) begin
				next_r.busy = 1'b1;
			end
			if (s.stop_det) begin
				next_r.busy = 1'b0;
				ev_set[EV_STOP] = 1'b1;
			end
			// joins a low clock only; a high line is left alone
			next_r.hold_scl = (r.si | r.load_pend) &
				(r.hold_scl | ~s.scl);
			if (r.timer != '0) begin
				next_r.timer = r.timer - TIMER_ONE;
			end
			if (r.stop_request_bit && !r.master) begin
				next_r.stop_request_bit = 1'b0;
				next_r.addressed = 1'b0;
				next_r.drv_sda = 1'b0;
				next_r.load_pend = 1'b0;
				next_r.st = S_IDLE;
				// unaddressed again: no relevant state, flag untouched
				load = 1'b1;
				load_val = C_IDLE;
			end else if ((r.st == S_IDLE || r.st == S_WAIT_FREE ||
				r.st == S_BUF) && s.start_det) begin
				next_r.st = S_SLV;
				// first clock fall after a start carries no bit
				next_r.bitcnt = '1;
				next_r.addr_byte = 1'b1;
				next_r.tx = 1'b0;
			end else begin
				unique case (r.st)
					S_IDLE: begin
						if (r.start_request_bit && !r.si) begin
							if (r.busy) begin
								next_r.st = S_WAIT_FREE;
							end else begin
								next_r.st = S_BUF;
								next_r.timer = BUF_LOAD;
							end
						end
					end
					S_WAIT_FREE: begin
						if (s.stop_det) begin
							next_r.st = S_BUF;
							next_r.timer = BUF_LOAD;
						end
					end
					S_BUF: begin
						if (!r.start_request_bit) begin
							next_r.st = S_IDLE;
						end else if (r.timer == '0) begin
							next_r.st = S_START;
							next_r.phase = 2'd0;
							next_r.timer = QUARTER_LOAD;
							next_r.rep = 1'b0;
						end
					end
					S_START: begin
						if (r.phase == 2'd0) begin
							if (r.timer == '0 && s.scl) begin
								next_r.drv_sda = 1'b1;
								next_r.phase = 2'd1;
								next_r.timer = QUARTER_LOAD;
							end
						end else if (r.timer == '0) begin
							next_r.drv_scl = 1'b1;
							next_r.master = 1'b1;
							next_r.tx = 1'b1;
							next_r.addr_byte = 1'b1;
							next_r.byte_done = 1'b0;
							load = 1'b1;
							load_val = r.rep ? C_RSTART : C_START;
							next_r.st = S_HOLD;
						end
					end
					S_HOLD: begin
						next_r.phase = 2'd0;
						next_r.timer = QUARTER_LOAD;
						if (!r.si) begin
							if (r.stop_request_bit) begin
								next_r.st = S_STOP;
								next_r.drv_sda = 1'b1;
							end else if (r.start_request_bit && r.byte_done) begin
								next_r.st = S_RSTART;
								next_r.drv_sda = 1'b0;
							end else begin
								next_r.st = S_XFER;
								next_r.shreg = r.data;
								next_r.bitcnt = '0;
							end
						end
					end
					S_XFER: begin
						unique case (r.phase)
							2'd0: begin
								if (r.bitcnt != BIT_ACK) begin
									next_r.drv_sda = r.tx & ~r.shreg[7];
								end else begin
									next_r.drv_sda = ~r.tx & r.aa;
								end
								if (r.timer == '0) begin
									next_r.drv_scl = 1'b0;
									next_r.phase = 2'd1;
									next_r.timer = QUARTER_LOAD;
								end
							end
							2'd1: begin
								if (!s.scl) begin
									// a slave is stretching
									next_r.timer = QUARTER_LOAD;
								end else if (r.timer == '0) begin
									next_r.phase = 2'd2;
									next_r.timer = QUARTER_LOAD;
									if (r.bitcnt != BIT_ACK) begin
										next_r.shreg = {r.shreg[6:0], s.sda};
										if (r.tx && !r.drv_sda && !s.sda) begin
											next_r.master = 1'b0;
											next_r.drv_sda = 1'b0;
											next_r.st = S_IDLE;
											load = 1'b1;
											load_val = C_LOST;
											ev_set[EV_LOST] = 1'b1;
										end
									end else begin
										next_r.acked = ~s.sda;
									end
								end
							end
							2'd2: begin
								if (r.timer == '0) begin
									next_r.drv_scl = 1'b1;
									next_r.phase = 2'd3;
									next_r.timer = QUARTER_LOAD;
								end
							end
							2'd3: begin
								if (r.timer == '0) begin
									next_r.phase = 2'd0;
									next_r.timer = QUARTER_LOAD;
									if (r.bitcnt == BIT_ACK) begin
										next_r.drv_sda = 1'b0;
										next_r.byte_done = 1'b1;
										next_r.addr_byte = 1'b0;
										next_r.st = S_HOLD;
										load = 1'b1;
										if (r.addr_byte) begin
											next_r.tx = ~r.shreg[0];
											if (r.shreg[0]) begin
												load_val = r.acked ? C_AR_ACK : C_AR_NACK;
											end else begin
												load_val = r.acked ? C_AW_ACK : C_AW_NACK;
											end
										end else if (r.tx) begin
											load_val = r.acked ? C_DW_ACK : C_DW_NACK;
										end else begin
											next_r.data = r.shreg;
											load_val = r.acked ? C_DR_ACK : C_DR_NACK;
										end
									end else begin
										next_r.bitcnt = r.bitcnt + 4'h1;
									end
								end
							end
						endcase
					end
					S_STOP: begin
						if (r.phase == 2'd0) begin
							if (r.timer == '0) begin
								next_r.drv_scl = 1'b0;
								next_r.phase = 2'd1;
								next_r.timer = QUARTER_LOAD;
							end
						end else if (r.phase == 2'd1) begin
							if (!s.scl) begin
								next_r.timer = QUARTER_LOAD;
							end else if (r.timer == '0) begin
								next_r.drv_sda = 1'b0;
								next_r.phase = 2'd2;
							end
						end else if (s.stop_det) begin
							next_r.stop_request_bit = 1'b0;
							next_r.master = 1'b0;
							next_r.st = S_IDLE;
							load = 1'b1;
							load_val = C_IDLE;
						end
					end
					S_RSTART: begin
						if (r.timer == '0) begin
							next_r.drv_scl = 1'b0;
							next_r.st = S_START;
							next_r.phase = 2'd0;
							next_r.timer = QUARTER_LOAD;
							next_r.rep = 1'b1;
						end
					end
					S_SLV: begin
						if (s.start_det) begin
							next_r.bitcnt = '1;
							next_r.addr_byte = 1'b1;
							next_r.addressed = 1'b0;
							next_r.drv_sda = 1'b0;
							next_r.tx = 1'b0;
						end else if (s.stop_det) begin
							if (r.addressed) begin
								load = 1'b1;
								load_val = C_SSTOP;
							end
							next_r.addressed = 1'b0;
							next_r.drv_sda = 1'b0;
							next_r.load_pend = 1'b0;
							next_r.st = S_IDLE;
						end else if (r.load_pend && !r.si) begin
							// clock is still held one more cycle
							next_r.shreg = r.data;
							next_r.drv_sda = ~r.data[7];
							next_r.load_pend = 1'b0;
						end else if (s.scl_rise) begin
							if (r.bitcnt != BIT_ACK) begin
								next_r.shreg = {r.shreg[6:0], s.sda};
							end else if (r.tx) begin
								next_r.acked = ~s.sda;
							end
						end else if (s.scl_fall) begin
							if (r.bitcnt == BIT_LAST) begin
								next_r.bitcnt = BIT_ACK;
								if (r.addr_byte) begin
									match_own = r.shreg[7:1] == r.own[7:1];
									match_gc = r.own[GC_BIT] &&
										r.shreg == 8'h00;
									if ((match_own || match_gc) && r.aa) begin
										next_r.drv_sda = 1'b1;
										next_r.gcall = match_gc;
										next_r.tx = r.shreg[0] & match_own;
									end else begin
										next_r.st = S_IDLE;
									end
								end else if (r.tx) begin
									next_r.drv_sda = 1'b0;
								end else begin
									next_r.drv_sda = r.aa;
									next_r.acked = r.aa;
								end
							end else if (r.bitcnt == BIT_ACK) begin
								next_r.drv_sda = 1'b0;
								next_r.bitcnt = '0;
								load = 1'b1;
								if (r.addr_byte) begin
									next_r.addressed = 1'b1;
									next_r.addr_byte = 1'b0;
									next_r.load_pend = r.tx;
									if (r.tx) begin
										load_val = C_SA_R;
									end else begin
										load_val = r.gcall ? C_GC_W : C_SA_W;
									end
								end else if (r.tx) begin
									next_r.load_pend = r.acked;
									next_r.addressed = r.acked;
									load_val = r.acked ? C_ST_ACK : C_ST_NACK;
								end else begin
									next_r.data = r.shreg;
									next_r.addressed = r.acked;
									if (r.gcall) begin
										load_val = r.acked ? C_GD_ACK : C_GD_NACK;
									end else begin
										load_val = r.acked ? C_SD_ACK : C_SD_NACK;
									end
								end
							end else begin
								next_r.bitcnt = r.bitcnt + 4'h1;
								next_r.drv_sda = r.tx & ~r.shreg[7];
							end
						end
					end
				endcase
			end
		end

		// hardware set beats a same-cycle software clear
		if (load) begin
			next_r.code = load_val;
			if (load_val != C_IDLE) begin
				next_r.si = 1'b1;
				ev_set[EV_STATE] = 1'b1;
			end
		end
		next_r.ev = next_r.ev | ev_set;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.st <= S_IDLE;
			r.code <= C_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	always_comb begin
		rd = '0;
		unique case (r.ap_addr)
			OFF_CTRL: begin
				rd[CTL_ENS] = r.ens;
				rd[CTL_STA] = r.start_request_bit;
				rd[CTL_STO] = r.stop_request_bit;
				rd[CTL_SI] = r.si;
				rd[CTL_AA] = r.aa;
			end
			OFF_CODE: rd[7:0] = r.code;
			OFF_DATA: rd[7:0] = r.data;
			OFF_OWN: rd[7:0] = r.own;
			OFF_IEN: begin
				rd[IEN_GLOBAL] = r.glob_en;
				rd[IEN_SERIAL] = r.ser_en;
			end
			OFF_EV: rd[EV_W-1:0] = r.ev;
			OFF_MASK: rd[EV_W-1:0] = r.ev_mask;
			default: ;
		endcase
	end

	assign hrdata = (r.ap_valid && !r.ap_write) ? rd : '0;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign serial_irq = r.si & r.glob_en & r.ser_en;
	assign irq = |(r.ev & r.ev_mask);
	assign line_out = '0;
	assign line_oe.scl = r.drv_scl | r.hold_scl;
	assign line_oe.sda = r.drv_sda;

endmodule

// ---- two_wire_pkg.sv ----
package two_wire_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_NS = 5;
	localparam int T_QUARTER_NS = 2500;
	localparam int T_BUF_NS = 4700;
	localparam int QUARTER_CYC = (T_QUARTER_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUF_CYC = (T_BUF_NS + CLK_NS - 1) / CLK_NS;
	localparam int TIMER_W = 10;
	localparam logic [TIMER_W-1:0] QUARTER_LOAD = TIMER_W'(QUARTER_CYC);
	localparam logic [TIMER_W-1:0] BUF_LOAD = TIMER_W'(BUF_CYC);
	localparam logic [TIMER_W-1:0] TIMER_ONE = TIMER_W'(1);

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CODE = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_OWN = 8'h0C;
	localparam logic [7:0] OFF_IEN = 8'h10;
	localparam logic [7:0] OFF_EV = 8'h14;
	localparam logic [7:0] OFF_MASK = 8'h18;

	localparam int CTL_ENS = 6;
	localparam int CTL_STA = 5;
	localparam int CTL_STO = 4;
	localparam int CTL_SI = 3;
	localparam int CTL_AA = 2;
	localparam int GC_BIT = 0;
	localparam int IEN_GLOBAL = 1;
	localparam int IEN_SERIAL = 0;
	localparam int EV_STATE = 0;
	localparam int EV_STOP = 1;
	localparam int EV_LOST = 2;
	localparam int EV_W = 3;

	// ************************************************************
	// bus state codes
	// ************************************************************
	localparam logic [7:0] C_START = 8'h08;
	localparam logic [7:0] C_RSTART = 8'h10;
	localparam logic [7:0] C_AW_ACK = 8'h18;
	localparam logic [7:0] C_AW_NACK = 8'h20;
	localparam logic [7:0] C_DW_ACK = 8'h28;
	localparam logic [7:0] C_DW_NACK = 8'h30;
	localparam logic [7:0] C_LOST = 8'h38;
	localparam logic [7:0] C_AR_ACK = 8'h40;
	localparam logic [7:0] C_AR_NACK = 8'h48;
	localparam logic [7:0] C_DR_ACK = 8'h50;
	localparam logic [7:0] C_DR_NACK = 8'h58;
	localparam logic [7:0] C_SA_W = 8'h60;
	localparam logic [7:0] C_GC_W = 8'h70;
	localparam logic [7:0] C_SD_ACK = 8'h80;
	localparam logic [7:0] C_SD_NACK = 8'h88;
	localparam logic [7:0] C_GD_ACK = 8'h90;
	localparam logic [7:0] C_GD_NACK = 8'h98;
	localparam logic [7:0] C_SSTOP = 8'hA0;
	localparam logic [7:0] C_SA_R = 8'hA8;
	localparam logic [7:0] C_ST_ACK = 8'hB8;
	localparam logic [7:0] C_ST_NACK = 8'hC0;
	localparam logic [7:0] C_IDLE = 8'hF8;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic scl;
		logic sda;
	} line_pair_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start_det;
		logic stop_det;
	} bus_sense_t;

	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_WAIT_FREE = 9'h002,
		S_BUF = 9'h004,
		S_START = 9'h008,
		S_HOLD = 9'h010,
		S_XFER = 9'h020,
		S_STOP = 9'h040,
		S_RSTART = 9'h080,
		S_SLV = 9'h100
	} ctl_state_t;

endpackage

// ---- bus_sense.sv ----
`timescale 1ns/1ps
module bus_sense
	import two_wire_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire line_pair_t line_in,
	output bus_sense_t sense
);

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
	} sense_state_t;

	sense_state_t r;
	sense_state_t next_r;

	always_comb begin
		next_r.s1 = {line_in.scl, line_in.sda};
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			// idle lines are high: no false edge right after reset
			r <= '1;
		end else begin
			r <= next_r;
		end
	end

	// only s2 and s3 are looked at; s1 may be metastable
	always_comb begin
		sense.scl = r.s2[1];
		sense.sda = r.s2[0];
		sense.scl_rise = r.s2[1] & ~r.s3[1];
		sense.scl_fall = ~r.s2[1] & r.s3[1];
		sense.start_det = r.s2[1] & r.s3[1] & ~r.s2[0] & r.s3[0];
		sense.stop_det = r.s2[1] & r.s3[1] & r.s2[0] & ~r.s3[0];
	end

endmodule

// ---- two_wire_bus_control_properties.sv ----
`timescale 1ns/1ps
module two_wire_bus_control_properties
	import two_wire_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire line_pair_t line_in,
	input wire line_pair_t line_out,
	input wire line_pair_t line_oe,
	input wire logic serial_irq,
	input wire logic irq
);
	// ************************************************************
	// register shadow
	// ************************************************************
	logic dph, dwr, dw, ens, start_request_bit;
	logic [7:0] da;
	logic [1:0] ien;
	assign dw = dph && dwr;
	// address and direction only matter while dph is high
	always_ff @(posedge clock) begin
		dwr <= hwrite;
		da <= haddr[7:0];
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dph <= 1'b0;
			ens <= 1'b0;
			start_request_bit <= 1'b0;
			ien <= 2'h0;
		end else begin
			dph <= hsel && hready && htrans[1];
			if (dw && da == OFF_CTRL) begin
				ens <= hwdata[CTL_ENS];
				start_request_bit <= hwdata[CTL_STA];
			end
			if (dw && da == OFF_IEN) begin
				ien <= hwdata[1:0];
			end
		end
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	property p_released_off;
		(!ens) [*2] |-> line_oe == '0;
	endproperty
	a_released_off: assert property (p_released_off)
		else $error("bus driven while disabled");
	property p_no_start;
		$rose(line_oe.sda) && line_in.scl |-> start_request_bit;
	endproperty
	a_no_start: assert property (p_no_start)
		else $error("start without request");
	property p_flag_sw_clear;
		$fell(serial_irq) |-> $past(dw);
	endproperty
	a_flag_sw_clear: assert property (p_flag_sw_clear)
		else $error("event flag dropped without a write");
	property p_irq_sw_clear;
		$fell(irq) |-> $past(dw);
	endproperty
	a_irq_sw_clear: assert property (p_irq_sw_clear)
		else $error("sticky interrupt dropped without a write");
	property p_irq_enables;
		serial_irq |-> ien == 2'h3;
	endproperty
	a_irq_enables: assert property (p_irq_enables)
		else $error("serial interrupt while not enabled");
	property p_stretch;
		(serial_irq && !line_in.scl) [*4] |-> line_oe.scl;
	endproperty
	a_stretch: assert property (p_stretch)
		else $error("clock not held low while flag set");
	property p_unmapped;
		dph && !dwr && da > OFF_MASK |-> hrdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_open_drain;
		line_out == '0 && hreadyout && !hresp;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("line driven high or bus not ready");
	c_stretch: cover property (serial_irq && line_oe.scl);
	c_start: cover property ($rose(line_oe.sda) && line_in.scl);
	c_unmapped: cover property (dph && !dwr && da > OFF_MASK);
endmodule

bind two_wire_bus_control two_wire_bus_control_properties u_props (
	.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.line_in(line_in), .line_out(line_out), .line_oe(line_oe),
	.serial_irq(serial_irq), .irq(irq)
);

// ---- far_master.sv ----
`timescale 1ns/1ps
module far_master
	import two_wire_pkg::*;
(
	input wire logic scl_bus,
	input wire logic sda_bus,
	output line_pair_t pull
);
	// ************************************************************
	// far bus master, 64 ns clock, idle outside frames
	// ************************************************************
	initial pull = '0;
	int stuck = 0;
	// bounded so a stuck stretch cannot hang the run
	task automatic rise_scl;
		int n = 0;
		pull.scl = 1'b0;
		while (scl_bus !== 1'b1 && n < 20000) begin
			#1;
			n++;
		end
		if (n >= 20000) stuck++;
	endtask
	task automatic start_c;
		pull.sda = 1'b1;
		#32;
		pull.scl = 1'b1;
		#16;
	endtask
	task automatic send(input logic [7:0] b, output logic nack);
		for (int i = 7; i >= 0; i--) begin
			pull.sda = ~b[i];
			#16;
			rise_scl();
			#32;
			pull.scl = 1'b1;
			#16;
		end
		pull.sda = 1'b0;
		#16;
		rise_scl();
		#32;
		nack = sda_bus;
		pull.scl = 1'b1;
		#16;
	endtask
	task automatic stop_c;
		pull.sda = 1'b1;
		#16;
		rise_scl();
		#32;
		pull.sda = 1'b0;
		#32;
	endtask
endmodule

// ---- two_wire_bus_control_tb.sv ----
`timescale 1ns/1ps
module two_wire_bus_control_tb
	import two_wire_pkg::*;
;
	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] own;
		logic [7:0] adr;
		logic [7:0] code;
	} row_t;
	logic clock, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic serial_irq, irq, nack, scl_bus, sda_bus;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	line_pair_t line_in, line_out, line_oe, far_pull;
	int fail_count, num_checks, starts, stops, s0;
	row_t rows [6] = '{
		'{8'h44, 8'h54, 8'h54, C_SA_W},
		'{8'h44, 8'h54, 8'h56, 8'h00},
		'{8'h44, 8'h54, 8'h00, 8'h00},
		'{8'h44, 8'h55, 8'h00, C_GC_W},
		'{8'h40, 8'h54, 8'h54, 8'h00},
		'{8'h04, 8'h54, 8'h54, 8'h00}};
	// pull-ups: a released line reads high
	assign hready = hreadyout;
	assign scl_bus = !(line_oe.scl || far_pull.scl);
	assign sda_bus = !(line_oe.sda || far_pull.sda);
	assign line_in = {scl_bus, sda_bus};
	two_wire_bus_control DUT (
		.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .line_in(line_in), .line_out(line_out),
		.line_oe(line_oe), .serial_irq(serial_irq), .irq(irq)
	);
	far_master u_far (.scl_bus(scl_bus), .sda_bus(sda_bus), .pull(far_pull));
	always @(negedge sda_bus)
		if (scl_bus === 1'b1) starts++;
	always @(posedge sda_bus)
		if (scl_bus === 1'b1) stops++;
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// ************************************************************
	// access tasks
	// ************************************************************
	task automatic conclude;
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n = 0;
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do
			@(posedge clock);
		while (hready !== 1'b1 && ++n < 20);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do
			@(posedge clock);
		while (hready !== 1'b1 && ++n < 20);
		rd = hrdata;
		if (hready !== 1'b1) begin
			fail_count++;
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	// waits for the event flag, or for a stop seen on the wire
	task automatic wait_for(input logic on_stop, input int lim);
		int n = 0;
		int s = stops;
		@(posedge clock);
		while ((on_stop ? stops == s : serial_irq !== 1'b1) && n < lim) begin
			@(posedge clock);
			n++;
		end
		if (n >= lim) begin
			fail_count++;
			conclude();
		end
	endtask
	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rdck(OFF_CODE, 32'hF8);
		rdck(OFF_CTRL, 32'h0);
		rdck(8'h40, 32'h0);
		wr(OFF_IEN, 32'h3);
		wr(OFF_MASK, 32'h1);
		s0 = starts;
		wr(OFF_CTRL, 32'h30);
		repeat (2 * BUF_CYC) @(posedge clock);
		check(starts - s0, 32'h0);
		rdck(OFF_CTRL, 32'h20);
		check(line_oe, 32'h0);
		wr(OFF_CTRL, 32'h0);
		foreach (rows[i]) begin
			wr(OFF_OWN, rows[i].own);
			wr(OFF_CTRL, rows[i].ctl);
			u_far.start_c();
			u_far.send(rows[i].adr, nack);
			check(nack, rows[i].code == 8'h0);
			if (rows[i].code != 8'h0) begin
				wait_for(1'b0, 200);
				rdck(OFF_CODE, rows[i].code);
				check(line_oe.scl, 1'b1);
				check(irq, 1'b1);
				rdck(OFF_CTRL, rows[i].ctl | 8'h08);
				wr(OFF_EV, 32'h7);
				wr(OFF_CTRL, rows[i].ctl | 8'h10);
				rdck(OFF_CTRL, rows[i].ctl);
				check(line_oe, 32'h0);
				check(serial_irq | irq, 1'b0);
			end else begin
				rdck(OFF_CODE, 32'hF8);
				check(serial_irq, 1'b0);
			end
			u_far.stop_c();
		end
		s0 = starts;
		wr(OFF_CTRL, 32'h64);
		wait_for(1'b0, 4000);
		check(starts - s0, 32'h1);
		rdck(OFF_CODE, C_START);
		check(line_oe.scl, 1'b1);
		wr(OFF_DATA, 32'hA4);
		wr(OFF_CTRL, 32'h44);
		wait_for(1'b0, 20000);
		rdck(OFF_CODE, C_AW_NACK);
		wr(OFF_CTRL, 32'h64);
		wait_for(1'b0, 4000);
		check(starts - s0, 32'h2);
		rdck(OFF_CODE, C_RSTART);
		s0 = starts;
		wr(OFF_CTRL, 32'h74);
		wait_for(1'b1, 4000);
		check(starts - s0, 32'h0);
		wait_for(1'b0, 4000);
		check(starts - s0, 32'h1);
		rdck(OFF_CODE, C_START);
		wr(OFF_CTRL, 32'h50);
		wait_for(1'b1, 4000);
		rdck(OFF_CTRL, 32'h40);
		rdck(OFF_CODE, 32'hF8);
		check(serial_irq, 1'b0);
		check(u_far.stuck, 32'h0);
		conclude();
	end
endmodule
